// [hdl/tps_timer.sv]
// module: timer0 clock select, prescaler, counter, compare and interrupts
`timescale 1ns/1ps
module tps_timer
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [tps_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic ext_count_pin,
   input wire logic capture_pin,
   output logic timer_tick,
   output logic irq
);
   import tps_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   // every flop outside the pin synchronizers sits in this one word, so a reset
   // or a register step can never leave two fields out of phase
   typedef struct packed {
      logic [PRESCALE_W-1:0] prescale;
      logic sync_halt_bit;
      logic prescaler_reset_bit;
      logic [2:0] clock_select_field;
      logic [2:0] ctrl_a;
      logic [7:0] count_low_byte;
      logic [7:0] count_high_byte;
      logic [7:0] compare_a_reg;
      logic [7:0] compare_b_reg;
      logic [3:0] timer_int_flags;
      logic [3:0] timer_int_mask;
      logic [7:0] rdata;
      logic irq;
      logic tick;
   } tps_timer_state_t;

   tps_timer_state_t state_reg;
   tps_timer_state_t state_next;

   // synchronized pin levels and their one-cycle-old copies
   logic ext_level;
   logic ext_prev;
   logic cap_level;
   logic cap_prev;

   // ------------------------------------------------------------------
   // pin synchronizers
   // ------------------------------------------------------------------
   // sample and synchronize
   // pin level is read whatever the pin direction
   tps_sync u_ext_sync
   (
      .clk(clk),
      .resetn(resetn),
      .pin_in(ext_count_pin),
      .level_out(ext_level),
      .prev_out(ext_prev)
   );

   // capture pin uses the same two-stage crossing
   tps_sync u_cap_sync
   (
      .clk(clk),
      .resetn(resetn),
      .pin_in(capture_pin),
      .level_out(cap_level),
      .prev_out(cap_prev)
   );

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // true in the last cycle of the selected prescaler period
   // after a prescaler clear the first hit is n cycles away
   function automatic logic tap_hit
   (
      input logic [PRESCALE_W-1:0] pre,
      input logic [PRESCALE_W-1:0] mask
   );
      tap_hit = ((pre & mask) == mask);
   endfunction : tap_hit

   // register address match, used only by the clock control write decode
   function automatic logic hit
   (
      input logic [ADDR_W-1:0] addr,
      input logic [7:0] ofs
   );
      hit = (addr == ofs);
   endfunction : hit

   // ------------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------------
   logic wr_cc;
   logic prescale_clear;
   logic halted;
   logic tick_now;
   logic ext_rise;
   logic ext_fall;
   logic cap_rise;
   logic wide;
   logic ctc;
   logic [15:0] count_now;
   logic [15:0] count_inc;
   logic [15:0] count_new;
   logic [15:0] compare_wide;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic [7:0] rd_mux;

   always_comb
   begin
      // defaults: each field holds unless a rule below moves it
      state_next = state_reg;
      wr_cc = reg_write && hit(reg_addr, OFS_CLOCK_CONTROL);
      wide = state_reg.ctrl_a[WIDE_BIT];
      ctc = state_reg.ctrl_a[CTC_BIT];
      count_now = {state_reg.count_high_byte, state_reg.count_low_byte};
      count_inc = count_now + 16'h0001;
      count_new = count_now;
      compare_wide = {state_reg.compare_b_reg, state_reg.compare_a_reg};
      flag_set = 4'h0;
      flag_clr = 4'h0;
      tick_now = 1'b0;

      // edge detector on synchronized copies only
      ext_rise = ext_level && !ext_prev;
      ext_fall = !ext_level && ext_prev;
      cap_rise = cap_level && !cap_prev;

      // a write of one resets the prescaler in that cycle
      // a held reset bit keeps the prescaler cleared
      prescale_clear = state_reg.prescaler_reset_bit ||
                       (wr_cc && reg_wdata[PSR_BIT]);
      // a prescaler clear halts every source, external edges too,
      // so nothing counts while software sets the timer up
      halted = prescale_clear;

      // free-running prescaler, blind to clock select
      if (prescale_clear)
      begin
         state_next.prescale = PRESCALE_RESET;
      end
      else
      begin
         state_next.prescale = state_reg.prescale + 10'h001;
      end

      case (state_reg.clock_select_field)
         CS_STOP: tick_now = 1'b0;
         CS_DIRECT: tick_now = !halted;
         // tap phase sets the first count delay
         CS_DIV8: tick_now = !halted && tap_hit(state_reg.prescale, TAP_DIV8);
         CS_DIV64:
            tick_now = !halted && tap_hit(state_reg.prescale, TAP_DIV64);
         CS_DIV256:
            tick_now = !halted && tap_hit(state_reg.prescale, TAP_DIV256);
         CS_DIV1024:
            tick_now = !halted && tap_hit(state_reg.prescale, TAP_DIV1024);
         // edges go to the tick without division
         CS_EXT_FALL: tick_now = !halted && ext_fall;
         CS_EXT_RISE: tick_now = !halted && ext_rise;
         default: tick_now = 1'b0;
      endcase

      // limitation: the count has no byte latch, so a byte-wise
      // read of a running 16-bit count can tear at the carry
      // tick from synchronized edge updates the counter next edge
      if (tick_now)
      begin
         if (wide)
         begin
            count_new = count_inc;
            if (count_inc == 16'h0000)
            begin
               flag_set[FLAG_OVF] = 1'b1;
            end
            // one 16-bit compare, A low and B high
            if (count_inc == compare_wide)
            begin
               flag_set[FLAG_CMPA] = 1'b1;
            end
         end
         else
         begin
            // clear-on-compare restarts the low byte from zero
            if (ctc && (state_reg.count_low_byte == state_reg.compare_a_reg))
            begin
               count_new = {state_reg.count_high_byte, 8'h00};
            end
            else
            begin
               count_new = {state_reg.count_high_byte, count_inc[7:0]};
            end
            if (state_reg.count_low_byte == 8'hff)
            begin
               flag_set[FLAG_OVF] = 1'b1;
            end
            if (count_new[7:0] == state_reg.compare_a_reg)
            begin
               flag_set[FLAG_CMPA] = 1'b1;
            end
            if (count_new[7:0] == state_reg.compare_b_reg)
            begin
               flag_set[FLAG_CMPB] = 1'b1;
            end
         end
      end
      state_next.count_low_byte = count_new[7:0];
      state_next.count_high_byte = count_new[15:8];

      // capture edge raises its flag only while enabled
      if (cap_rise && state_reg.ctrl_a[CAPEN_BIT])
      begin
         flag_set[FLAG_CAP] = 1'b1;
      end

      // an unmapped offset falls to the default and is lost
      // register writes; a cpu write to the count wins over a tick
      if (reg_write)
      begin
         case (reg_addr)
            OFS_CTRL_A: state_next.ctrl_a = reg_wdata[2:0];
            OFS_COUNT_LOW: state_next.count_low_byte = reg_wdata;
            OFS_COUNT_HIGH: state_next.count_high_byte = reg_wdata;
            OFS_COMPARE_A: state_next.compare_a_reg = reg_wdata;
            OFS_COMPARE_B: state_next.compare_b_reg = reg_wdata;
            OFS_INT_FLAGS: flag_clr = reg_wdata[3:0];
            OFS_INT_MASK: state_next.timer_int_mask = reg_wdata[3:0];
            default: flag_clr = 4'h0;
         endcase
      end

      // trade-off: the reset bit reads back one only while held
      // clock control: the reset bit is only kept in sync mode
      if (wr_cc)
      begin
         state_next.clock_select_field = reg_wdata[CS_LSB +: 3];
         state_next.sync_halt_bit = reg_wdata[TSM_BIT];
         // sync mode keeps the written value
         // otherwise hardware clears it at once
         state_next.prescaler_reset_bit =
            reg_wdata[PSR_BIT] && reg_wdata[TSM_BIT];
      end

      // sticky flags, a set beats a same-cycle clear
      state_next.timer_int_flags =
         (state_reg.timer_int_flags & ~flag_clr) | flag_set;

      // masked sources merge onto one level request
      state_next.irq =
         |(state_next.timer_int_flags & state_next.timer_int_mask);
      state_next.tick = tick_now;

      // read data stand only in the cycle after the strobe
      // idle cycles return zero so a stale byte never lingers
      rd_mux = BYTE_RESET;
      case (reg_addr)
         OFS_CTRL_A: rd_mux = {5'h00, state_reg.ctrl_a};
         OFS_COUNT_LOW: rd_mux = state_reg.count_low_byte;
         OFS_COUNT_HIGH: rd_mux = state_reg.count_high_byte;
         OFS_CLOCK_CONTROL:
            rd_mux = {3'h0, state_reg.sync_halt_bit,
                      state_reg.prescaler_reset_bit,
                      state_reg.clock_select_field};
         OFS_COMPARE_A: rd_mux = state_reg.compare_a_reg;
         OFS_COMPARE_B: rd_mux = state_reg.compare_b_reg;
         OFS_INT_FLAGS: rd_mux = {4'h0, state_reg.timer_int_flags};
         OFS_INT_MASK: rd_mux = {4'h0, state_reg.timer_int_mask};
         default: rd_mux = BYTE_RESET;
      endcase
      state_next.rdata = reg_read ? rd_mux : BYTE_RESET;
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   // synchronous reset, all fields to their documented values;
   // each field is reset on its own so its value stays tied to
   // the named constant that defines it
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_reg.prescale <= PRESCALE_RESET;
         state_reg.sync_halt_bit <= CLOCK_CONTROL_RESET[TSM_BIT];
         state_reg.prescaler_reset_bit <= CLOCK_CONTROL_RESET[PSR_BIT];
         state_reg.clock_select_field <= CLOCK_CONTROL_RESET[CS_LSB +: 3];
         state_reg.ctrl_a <= CTRL_A_RESET;
         state_reg.count_low_byte <= BYTE_RESET;
         state_reg.count_high_byte <= BYTE_RESET;
         state_reg.compare_a_reg <= BYTE_RESET;
         state_reg.compare_b_reg <= BYTE_RESET;
         state_reg.timer_int_flags <= FLAGS_RESET;
         state_reg.timer_int_mask <= MASK_RESET;
         state_reg.rdata <= BYTE_RESET;
         state_reg.irq <= 1'b0;
         state_reg.tick <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   // with no gate after the flop, so no glitch reaches a pin
   assign reg_rdata = state_reg.rdata;
   assign irq = state_reg.irq;
   assign timer_tick = state_reg.tick;

endmodule : tps_timer

// [hdl/tps_pkg.sv]
// package: register map, field layout and constants of the timer prescaler
package tps_pkg;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL_A = 8'h30;
   localparam logic [7:0] OFS_COUNT_LOW = 8'h31;
   localparam logic [7:0] OFS_COUNT_HIGH = 8'h32;
   localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h33;
   localparam logic [7:0] OFS_COMPARE_A = 8'h34;
   localparam logic [7:0] OFS_COMPARE_B = 8'h35;
   localparam logic [7:0] OFS_INT_FLAGS = 8'h36;
   localparam logic [7:0] OFS_INT_MASK = 8'h37;

   // ------------------------------------------------------------------
   // clock control fields
   // ------------------------------------------------------------------
   localparam int CS_LSB = 0;
   localparam int PSR_BIT = 3;
   localparam int TSM_BIT = 4;
   localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;

   // clock select encodings
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIRECT = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // prescaler width and tap masks (all low bits ones = end of period)
   localparam int PRESCALE_W = 10;
   localparam logic [9:0] TAP_DIV8 = 10'h007;
   localparam logic [9:0] TAP_DIV64 = 10'h03f;
   localparam logic [9:0] TAP_DIV256 = 10'h0ff;
   localparam logic [9:0] TAP_DIV1024 = 10'h3ff;
   localparam logic [9:0] PRESCALE_RESET = 10'h000;

   // ------------------------------------------------------------------
   // control A fields
   // ------------------------------------------------------------------
   localparam int CTC_BIT = 0;
   localparam int WIDE_BIT = 1;
   localparam int CAPEN_BIT = 2;
   localparam logic [2:0] CTRL_A_RESET = 3'h0;

   // ------------------------------------------------------------------
   // interrupt flag and mask layout
   // ------------------------------------------------------------------
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMPA = 1;
   localparam int FLAG_CMPB = 2;
   localparam int FLAG_CAP = 3;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage : tps_pkg

// [hdl/tps_sync.sv]
// module: two-stage pin synchronizer with an edge history stage
`timescale 1ns/1ps
module tps_sync
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic pin_in,
   output logic level_out,
   output logic prev_out
);
   import tps_pkg::*;

   typedef struct packed {
      logic meta;
      logic stable;
      logic prev;
   } tps_sync_state_t;

   tps_sync_state_t state_reg;
   tps_sync_state_t state_next;

   // shift chain; the first stage feeds only the second stage
   always_comb
   begin
      state_next = state_reg;
      state_next.meta = pin_in;
      state_next.stable = state_reg.meta;
      state_next.prev = state_reg.stable;
   end

   // synchronous active-low reset to idle low
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign level_out = state_reg.stable;
   assign prev_out = state_reg.prev;

endmodule : tps_sync

// [dv/tps_ext_src.sv]
// partner: external count source driving the timer count pin
`timescale 1ns/1ps
module tps_ext_src
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic en,
   input wire logic [3:0] half,
   output logic pin
);
   logic [3:0] cnt_reg;
   // toggles only while enabled, each level half cycles
   always_ff @(posedge clk)
   begin
      if (!resetn || !en)
      begin
         cnt_reg <= 4'h1;
      end
      else
      begin
         cnt_reg <= (cnt_reg >= half) ? 4'h1 : cnt_reg + 4'h1;
      end
      if (!resetn)
      begin
         pin <= 1'b0;
      end
      else if (en && cnt_reg >= half)
      begin
         pin <= ~pin;
      end
   end
endmodule : tps_ext_src

// [dv/tps_checker.sv]
// checker: port-level timing properties of the timer prescaler
`timescale 1ns/1ps
module tps_checker
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [tps_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic ext_count_pin,
   input wire logic timer_tick,
   input wire logic irq
);
   import tps_pkg::*;
   // ---------------------------------------------------------------
   // shadow state
   // ---------------------------------------------------------------
   logic [7:0] ctl_reg;
   logic [3:0] msk_reg;
   logic [3:0] age_reg;
   logic [3:0] gap_reg;
   logic held;
   logic [2:0] cs;
   logic ctl_wr;
   assign cs = ctl_reg[2:0];
   assign ctl_wr = reg_write && reg_addr == OFS_CLOCK_CONTROL;
   // reset is held only while both sync-halt and reset bits are set
   assign held = ctl_reg[TSM_BIT] & ctl_reg[PSR_BIT];
   // age: cycles since a control write; gap: cycles since a tick
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ctl_reg <= 8'h00;
         msk_reg <= 4'h0;
         age_reg <= 4'h0;
         gap_reg <= 4'h0;
      end
      else
      begin
         ctl_reg <= ctl_wr ? reg_wdata : ctl_reg;
         if (reg_write && reg_addr == OFS_INT_MASK)
         begin
            msk_reg <= reg_wdata[3:0];
         end
         age_reg <= ctl_wr ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
         gap_reg <= timer_tick ? 4'h1 : gap_reg + {3'h0, gap_reg != 4'hf};
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_direct_tick: assert property (
      cs == CS_DIRECT && !held && age_reg > 4'h4 |-> timer_tick)
      else $error("direct select missed a tick");
   a_stop_quiet: assert property (
      cs == CS_STOP && age_reg > 4'h4 |-> !timer_tick)
      else $error("tick while stopped");
   a_sync_halt: assert property (
      held && age_reg > 4'h4 |-> !timer_tick)
      else $error("tick while prescaler held");
   a_div8_gap: assert property (
      timer_tick && cs == CS_DIV8 && age_reg == 4'hf |-> gap_reg == 4'h8)
      else $error("divide by 8 spacing wrong");
   a_first_tick: assert property (
      cs == CS_DIV8 && !held && age_reg == 4'h1 |-> ##[0:11] timer_tick)
      else $error("first prescaled tick late");
   a_ext_rise: assert property (
      cs == CS_EXT_RISE && age_reg > 4'h4 && $rose(ext_count_pin)
      |-> ##[2:4] timer_tick)
      else $error("rising edge not counted in time");
   a_ext_polar: assert property (
      cs == CS_EXT_RISE && age_reg > 4'h4 && $fell(ext_count_pin)
      |=> !timer_tick [*3])
      else $error("falling edge counted in rising mode");
   a_irq_masked: assert property (
      msk_reg == 4'h0 && $past(msk_reg) == 4'h0 |-> !irq)
      else $error("interrupt with all sources masked");
   c_ext_tick: cover property (cs == CS_EXT_RISE && timer_tick);
   c_div8_tick: cover property (cs == CS_DIV8 && timer_tick);
   c_irq: cover property (irq);
endmodule : tps_checker

// [dv/tb_top.sv]
// testbench: registers, prescaler taps, external count, interrupts
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("Error at %0t: got %0h exp %0h", $time, got, exp); \
      end \
   end
module tb_top;
   import tps_pkg::*;
   // ---------------------------------------------------------------
   // signals, bench model and tasks
   // ---------------------------------------------------------------
   logic clk, resetn, reg_write, reg_read, capture_pin, en, pin, pq;
   logic timer_tick, irq;
   logic [ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [3:0] half;
   int error_cnt, n_tests, t_cnt, r_cnt, f_cnt, k;
   int mdl[8];
   int div_q[$];
   tps_timer i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .ext_count_pin(pin),
      .capture_pin(capture_pin), .timer_tick(timer_tick), .irq(irq));
   tps_ext_src i_src (.clk(clk), .resetn(resetn), .en(en), .half(half),
      .pin(pin));
   // free-running 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   // read data is taken at the edge after the read edge
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(posedge clk);
      `CHK(reg_rdata, e)
   endtask : rd_chk
   task automatic clr();
      t_cnt = 0;
      r_cnt = 0;
      f_cnt = 0;
      pq = pin;
   endtask : clr
   // counts ticks and pin edges; the source is gated by e
   task automatic run(input int n, input logic e);
      en <= e;
      repeat (n)
      begin
         @(posedge clk);
         t_cnt += (timer_tick === 1'b1) ? 1 : 0;
         r_cnt += (pin === 1'b1 && pq === 1'b0) ? 1 : 0;
         f_cnt += (pin === 1'b0 && pq === 1'b1) ? 1 : 0;
         pq = pin;
      end
   endtask : run
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   // main sequence
   initial
   begin
      {resetn, reg_write, reg_read, capture_pin, en} = 5'h00;
      {reg_addr, reg_wdata, half} = 20'h00004;
      {error_cnt, n_tests, pq} = 0;
      div_q = '{1, 8, 64, 256, 1024};
      mdl = '{default: 0};
      k = $urandom(16);
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      for (int a = 0; a < 8; a++)
         rd_chk(OFS_CTRL_A + 8'(a), 8'(mdl[a]));
      wr(OFS_CLOCK_CONTROL, 8'he0);
      rd_chk(OFS_CLOCK_CONTROL, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         wr(OFS_CLOCK_CONTROL, 8'(i));
         run(4, 1'b0);
         clr();
         run((i == 0) ? 64 : 2 * div_q[i - 1], 1'b0);
         `CHK(t_cnt, (i == 0) ? 0 : 2)
      end
      $display("test taps done");
      wr(OFS_CLOCK_CONTROL, 8'h19);
      run(4, 1'b0);
      clr();
      run(20, 1'b0);
      `CHK(t_cnt, 0)
      rd_chk(OFS_CLOCK_CONTROL, 8'h19);
      wr(OFS_CLOCK_CONTROL, 8'h01);
      rd_chk(OFS_CLOCK_CONTROL, 8'h01);
      wr(OFS_CLOCK_CONTROL, 8'h0d);
      k = 0;
      // the tick of the old direct select still stands at the write edge
      do
      begin
         @(posedge clk);
         k++;
      end
      while (timer_tick !== 1'b1 && k <= 1100);
      // a wait that runs out counts as a mismatch
      if (k > 1100)
      begin
         error_cnt++;
      end
      `CHK(k >= 1 && k <= 1027, 1'b1)
      rd_chk(OFS_CLOCK_CONTROL, 8'h05);
      $display("test reset bit done");
      // select changes only while the source is stopped
      for (int m = 6; m < 8; m++)
      begin
         wr(OFS_CLOCK_CONTROL, 8'(m));
         wr(OFS_COUNT_LOW, 8'h00);
         half <= 4'(4 + $urandom % 5);
         run(4, 1'b0);
         clr();
         run(200, 1'b1);
         run(10, 1'b0);
         k = (m == 7) ? r_cnt : f_cnt;
         `CHK(t_cnt, k)
         rd_chk(OFS_COUNT_LOW, 8'(k));
      end
      $display("test external done");
      wr(OFS_CLOCK_CONTROL, 8'h00);
      wr(OFS_COMPARE_A, 8'h03);
      wr(OFS_COMPARE_B, 8'h05);
      wr(OFS_INT_FLAGS, 8'h0f);
      wr(OFS_COUNT_LOW, 8'hfe);
      wr(OFS_CLOCK_CONTROL, 8'h01);
      run(20, 1'b0);
      wr(OFS_CLOCK_CONTROL, 8'h00);
      rd_chk(OFS_INT_FLAGS, 8'h07);
      rd_chk(OFS_COUNT_HIGH, 8'h00);
      rd_chk(OFS_COUNT_LOW, 8'h14);
      `CHK(irq, 1'b0)
      wr(OFS_INT_MASK, 8'h01);
      run(2, 1'b0);
      `CHK(irq, 1'b1)
      wr(OFS_INT_FLAGS, 8'h01);
      rd_chk(OFS_INT_FLAGS, 8'h06);
      `CHK(irq, 1'b0)
      wr(OFS_INT_FLAGS, 8'h0f);
      wr(OFS_CTRL_A, 8'h04);
      capture_pin <= 1'b1;
      run(6, 1'b0);
      rd_chk(OFS_INT_FLAGS, 8'h08);
      $display("test interrupts done");
      wr(OFS_INT_FLAGS, 8'h0f);
      wr(OFS_CTRL_A, 8'h02);
      wr(OFS_COMPARE_A, 8'h02);
      wr(OFS_COMPARE_B, 8'h01);
      wr(OFS_COUNT_LOW, 8'hff);
      wr(OFS_CLOCK_CONTROL, 8'h01);
      run(10, 1'b0);
      wr(OFS_CLOCK_CONTROL, 8'h00);
      rd_chk(OFS_COUNT_HIGH, 8'h01);
      rd_chk(OFS_INT_FLAGS, 8'h02);
      rd_chk(OFS_COUNT_LOW, 8'h0b);
      $display("test wide mode done");
      // clear on compare: 12 direct ticks from zero with top 4 end at 2
      wr(OFS_INT_FLAGS, 8'h0f);
      wr(OFS_CTRL_A, 8'h01);
      wr(OFS_COMPARE_A, 8'h04);
      wr(OFS_COMPARE_B, 8'h03);
      wr(OFS_COUNT_LOW, 8'h00);
      wr(OFS_CLOCK_CONTROL, 8'h01);
      run(10, 1'b0);
      wr(OFS_CLOCK_CONTROL, 8'h00);
      rd_chk(OFS_COUNT_LOW, 8'h02);
      rd_chk(OFS_INT_FLAGS, 8'h06);
      $display("test clear on compare done");
      print_verdict();
   end
endmodule : tb_top
bind tps_timer tps_checker i_chk (.clk(clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .ext_count_pin(ext_count_pin), .timer_tick(timer_tick), .irq(irq));
